// >>> core/logic_cluster.v
`include "logic_cluster_map.vh"

module logic_cluster #(
    parameter GLOBAL_CLEAR_EN = 1,
    parameter TOP_HALF_BYPASS = 1
) (
    // clock and synchronous reset
    input wire clk,
    input wire srst,
    // device-wide clear
    input wire global_clear_low,
    // cluster-wide asynchronous controls
    input wire clear_a,
    input wire clear_b,
    input wire preset,
    input wire [15:0] clear_sel,
    // cluster configuration
    input wire [1:0] mode,
    input wire [1:0] chain_start,
    input wire half_only,
    input wire reg_chain_en,
    // operands and direct register data
    input wire [15:0] op_x,
    input wire [15:0] op_y,
    input wire [15:0] op_z,
    input wire [15:0] reg_data,
    // chain links from the cluster above
    input wire carry_in,
    input wire shared_in,
    input wire reg_chain_in,
    // chain links to the cluster below
    output reg carry_out,
    output reg shared_out,
    output wire reg_chain_out,
    // results
    output wire [15:0] reg_q,
    output wire [15:0] comb_out
);

    wire [7:0] mod_cout;
    wire [7:0] mod_shout;
    wire [15:0] mod_sum;
    wire [15:0] q_r;
    reg [7:0] mod_cin;
    reg [7:0] mod_shin;
    reg [15:0] reg_d;
    reg lo_used;
    reg hi_used;
    reg entry_c;
    reg entry_s;
    wire global_clear_act;
    integer i;
    integer j;

    // one routing step of either add chain; modules outside the chain see zero
    function chain_step;
        input integer idx;
        input entry;
        input prev;
        input lo;
        input hi;
        begin
            if (idx == 0) begin
                chain_step = lo & entry;
            end else if (idx == `HALF_FIRST_MODULE) begin
                chain_step = hi & (lo ? prev : entry);
            end else if (idx < `HALF_FIRST_MODULE) begin
                chain_step = lo & prev;
            end else begin
                chain_step = hi & prev;
            end
        end
    endfunction

    // which halves take part, and what enters the chain
    always @* begin
        lo_used = (chain_start != `START_FIFTH) && (chain_start != `START_NONE) &&
                  !(half_only && (TOP_HALF_BYPASS != 0));
        hi_used = (chain_start != `START_NONE) && !(half_only && (TOP_HALF_BYPASS == 0));
        // a fresh start at the first or fifth module carries in zero
        entry_c = (chain_start == `START_CONTINUE) ? carry_in : 1'h0;
        entry_s = (chain_start == `START_CONTINUE) ? shared_in : 1'h0;
    end

    // carry and shared chains through the eight modules
    always @* begin
        mod_cin = 8'h00;
        mod_shin = 8'h00;
        for (i = 0; i < `MODULES_PER_CLUSTER; i = i + 1) begin
            mod_cin[i] = chain_step(i, entry_c, (i == 0) ? 1'h0 : mod_cout[i - 1], lo_used, hi_used);
            mod_shin[i] = chain_step(i, entry_s, (i == 0) ? 1'h0 : mod_shout[i - 1], lo_used, hi_used);
        end
    end

    // chain exit: last used module feeds the next cluster in the column
    always @* begin
        if (hi_used) begin
            carry_out = mod_cout[7];
            shared_out = mod_shout[7];
        end else if (lo_used) begin
            carry_out = mod_cout[3];
            shared_out = mod_shout[3];
        end else begin
            carry_out = 1'h0;
            shared_out = 1'h0;
        end
    end

    // the eight logic modules
    genvar m;
    generate
        for (m = 0; m < 8; m = m + 1) begin : g_mod
            logic_module_arith u_mod (
                .mode(mode),
                .op_x(op_x[2 * m + 1:2 * m]),
                .op_y(op_y[2 * m + 1:2 * m]),
                .op_z(op_z[2 * m + 1:2 * m]),
                .carry_in(mod_cin[m]),
                .shared_in(mod_shin[m]),
                .sum(mod_sum[2 * m + 1:2 * m]),
                .lut_out(comb_out[2 * m + 1:2 * m]),
                .carry_out(mod_cout[m]),
                .shared_out(mod_shout[m])
            );
        end
    endgenerate

    // register input select; the lookup result stays on comb_out while shifting
    always @* begin
        for (j = 0; j < `REGS_PER_CLUSTER; j = j + 1) begin
            if (reg_chain_en) begin
                reg_d[j] = (j == 0) ? reg_chain_in : q_r[j - 1];
            end else if (mode == `MODE_NORMAL) begin
                reg_d[j] = reg_data[j];
            end else begin
                reg_d[j] = mod_sum[j];
            end
        end
    end

    // global clear folded into every clear so it overrides preset and data
    assign global_clear_act = (GLOBAL_CLEAR_EN != 0) & ~global_clear_low;

    // sixteen registers sharing the cluster-wide controls
    genvar k;
    generate
        for (k = 0; k < 16; k = k + 1) begin : g_reg
            cluster_register u_reg (
                .clk(clk),
                .srst(srst),
                .async_clear(global_clear_act | (clear_sel[k] ? clear_b : clear_a)),
                .async_preset(preset),
                .d(reg_d[k]),
                .q_r(q_r[k])
            );
        end
    endgenerate

    assign reg_q = q_r;
    assign reg_chain_out = q_r[15];

endmodule // logic_cluster

// >>> include/logic_cluster_map.vh
`ifndef LOGIC_CLUSTER_MAP_VH
`define LOGIC_CLUSTER_MAP_VH

// cluster geometry
`define MODULES_PER_CLUSTER 8
`define REGS_PER_CLUSTER 16
`define HALF_FIRST_MODULE 4

// operating modes of the cluster logic
`define MODE_NORMAL 2'h0
`define MODE_ARITH 2'h1
`define MODE_SHARED 2'h2

// where the add chains enter the cluster
`define START_CONTINUE 2'h0
`define START_FIRST 2'h1
`define START_FIFTH 2'h2
`define START_NONE 2'h3

// values forced by the asynchronous controls and by reset
`define REG_CLEAR_VAL 1'h0
`define REG_PRESET_VAL 1'h1
`define REG_RESET_VAL 1'h0

`endif

// >>> core/cluster_register.v
`include "logic_cluster_map.vh"

module cluster_register (
    // clock and synchronous reset
    input wire clk,
    input wire srst,
    // asynchronous controls, already merged for this register
    input wire async_clear,
    input wire async_preset,
    // data
    input wire d,
    output reg q_r
);

    wire preset_act;

    // preset only counts while clear is low, so releasing clear under a held preset sets the flop at once
    assign preset_act = async_preset & ~async_clear;

    // clear is tested first so it wins over a simultaneous preset
    always @(posedge clk or posedge async_clear or posedge preset_act) begin
        if (async_clear) begin
            q_r <= `REG_CLEAR_VAL;
        end else if (preset_act) begin
            q_r <= `REG_PRESET_VAL;
        end else if (srst) begin
            q_r <= `REG_RESET_VAL;
        end else begin
            q_r <= d;
        end
    end

endmodule // cluster_register

// >>> core/logic_module_arith.v
`include "logic_cluster_map.vh"

module logic_module_arith (
    // mode of the owning cluster
    input wire [1:0] mode,
    // two bits of each operand
    input wire [1:0] op_x,
    input wire [1:0] op_y,
    input wire [1:0] op_z,
    // chain inputs from the previous module
    input wire carry_in,
    input wire shared_in,
    // results
    output reg [1:0] sum,
    output reg [1:0] lut_out,
    output reg carry_out,
    output reg shared_out
);

    reg [1:0] part_s;
    reg [1:0] part_c;
    reg [1:0] a;
    reg [1:0] b;
    reg c_mid;

    // first stage in the lookup logic, second stage in the two adders
    always @* begin
        part_s = op_x ^ op_y ^ op_z;
        part_c = (op_x & op_y) | (op_x & op_z) | (op_y & op_z);
        lut_out = part_s;
        if (mode == `MODE_SHARED) begin
            a = part_s;
            b = {part_c[0], shared_in};
            shared_out = part_c[1];
        end else if (mode == `MODE_ARITH) begin
            a = op_x;
            b = op_y;
            shared_out = 1'h0;
        end else begin
            a = 2'h0;
            b = 2'h0;
            shared_out = 1'h0;
        end
        // adder0 carries into adder1, adder1 leaves the module
        sum[0] = a[0] ^ b[0] ^ carry_in;
        c_mid = (a[0] & b[0]) | (a[0] & carry_in) | (b[0] & carry_in);
        sum[1] = a[1] ^ b[1] ^ c_mid;
        carry_out = (a[1] & b[1]) | (a[1] & c_mid) | (b[1] & c_mid);
    end

endmodule // logic_module_arith

// >>> sim/cluster_above_model.sv
module cluster_above_model (
    // fabric clock
    input wire logic clk,
    // values the cluster above will present next
    input wire logic [2:0] next_links,
    // chain links into this cluster
    output logic carry_in,
    output logic shared_in,
    output logic reg_chain_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // links change off the sampling edge, like a real upstream register would
    initial {carry_in, shared_in, reg_chain_in} = 3'h0;
    always @(negedge clk) begin
        {carry_in, shared_in, reg_chain_in} <= next_links;
    end
endmodule // cluster_above_model

// >>> sim/logic_cluster_props.sv
module logic_cluster_props (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // controls
    input wire logic global_clear_low,
    input wire logic clear_a,
    input wire logic clear_b,
    input wire logic preset,
    input wire logic [15:0] clear_sel,
    input wire logic [1:0] mode,
    input wire logic reg_chain_en,
    // data
    input wire logic [15:0] op_x,
    input wire logic [15:0] op_y,
    input wire logic [15:0] op_z,
    input wire logic [15:0] reg_data,
    input wire logic reg_chain_in,
    // results
    input wire logic reg_chain_out,
    input wire logic [15:0] reg_q,
    input wire logic [15:0] comb_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // no asynchronous control at all, so the clock alone decides
    wire quiet = !clear_a && !clear_b && !preset && global_clear_low;
    chk_clear_beats_preset: assert property (preset && clear_a |-> (reg_q & ~clear_sel) == 16'h0000)
        else $error("clear lost to preset");
    chk_preset_loads_one: assert property (quiet === 1'b0 && preset && !clear_a && !clear_b && global_clear_low
        |-> reg_q == 16'hffff)
        else $error("preset did not load ones");
    chk_global_clear_all: assert property (!global_clear_low |-> reg_q == 16'h0000)
        else $error("global clear did not clear");
    chk_sync_reset_zero: assert property (disable iff (1'b0) srst && quiet ##1 quiet |-> reg_q == 16'h0000)
        else $error("reset did not clear");
    chk_chain_tail_out: assert property (reg_chain_out == reg_q[15])
        else $error("chain exit differs from last register");
    chk_shift_one_step: assert property (quiet && reg_chain_en ##1 quiet
        |-> reg_q == {$past(reg_q[14:0]), $past(reg_chain_in)})
        else $error("shift chain step wrong");
    chk_data_capture: assert property (quiet && !reg_chain_en && mode == 2'h0 ##1 quiet
        |-> reg_q == $past(reg_data))
        else $error("register data not captured");
    chk_lookup_func: assert property (comb_out == (op_x ^ op_y ^ op_z))
        else $error("lookup output wrong");
endmodule // logic_cluster_props
bind logic_cluster logic_cluster_props u_props (.clk(clk), .srst(srst), .global_clear_low(global_clear_low),
    .clear_a(clear_a), .clear_b(clear_b), .preset(preset), .clear_sel(clear_sel), .mode(mode),
    .reg_chain_en(reg_chain_en), .op_x(op_x), .op_y(op_y), .op_z(op_z), .reg_data(reg_data),
    .reg_chain_in(reg_chain_in), .reg_chain_out(reg_chain_out), .reg_q(reg_q), .comb_out(comb_out));

// >>> sim/logic_cluster_bench.sv
module logic_cluster_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, global_clear_low = 1, clear_a = 0, clear_b = 0, preset = 0, half_only = 0;
    logic reg_chain_en = 0, carry_in, shared_in, reg_chain_in, carry_out, shared_out, reg_chain_out;
    logic [1:0] mode = 2'h0, chain_start = 2'h1;
    logic [15:0] clear_sel = 0, op_x = 0, op_y = 0, op_z = 0, reg_data = 0, reg_q, comb_out, x, y, z, dt, eq;
    logic [16:0] s;
    logic [17:0] t;
    logic sh;
    logic [2:0] links = 0;
    int mismatches = 0, checks = 0, i, k, j;
    // fabric clock, 4 ns
    initial forever #2 clk = ~clk;
    cluster_above_model u_above (.clk(clk), .next_links(links), .carry_in(carry_in), .shared_in(shared_in),
        .reg_chain_in(reg_chain_in));
    logic_cluster #(.GLOBAL_CLEAR_EN(1), .TOP_HALF_BYPASS(1)) u_dut (.clk(clk), .srst(srst),
        .global_clear_low(global_clear_low), .clear_a(clear_a), .clear_b(clear_b), .preset(preset),
        .clear_sel(clear_sel), .mode(mode), .chain_start(chain_start), .half_only(half_only),
        .reg_chain_en(reg_chain_en), .op_x(op_x), .op_y(op_y), .op_z(op_z), .reg_data(reg_data),
        .carry_in(carry_in), .shared_in(shared_in), .reg_chain_in(reg_chain_in), .carry_out(carry_out),
        .shared_out(shared_out), .reg_chain_out(reg_chain_out), .reg_q(reg_q), .comb_out(comb_out));
    task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report;
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog: the sequence needs about 50 cycles
    initial begin
        #2000;
        mismatches++;
        final_report;
    end
    // random traffic through every mode, then the asynchronous controls
    initial begin
        void'($urandom(32'h52d6));
        repeat (3) @(negedge clk);
        srst = 0;
        eq = 16'h0000;
        for (i = 0; i < 41; i++) begin
            @(negedge clk);
            chk("reg_q", reg_q, eq);
            k = i % 6;
            x = $urandom;
            y = $urandom;
            z = $urandom;
            dt = $urandom;
            // non-blocking so the upstream model deterministically applies last cycle's links
            links <= 3'($urandom);
            chain_start = (k == 4) ? 2'h2 : ((k == 5 || ((k == 1 || k == 2) && i[3])) ? 2'h0 : 2'h1);
            half_only = (k == 5);
            mode = (k == 3) ? 2'h0 : ((k > 3) ? 2'h1 : k[1:0]);
            reg_chain_en = (k == 3);
            {op_x, op_y, op_z, reg_data} = {x, y, z, dt};
            #1;
            chk("comb_out", comb_out, x ^ y ^ z);
            // the bench model keeps the previous expectation as the current register image
            case (k)
                0: eq = dt;
                1: begin
                    s = {1'b0, x} + y + ((chain_start == 2'h0) ? carry_in : 1'b0);
                    eq = s[15:0];
                    chk("carry_out", carry_out, s[16]);
                end
                2: begin
                    t = x + y + z + ((chain_start == 2'h0) ? carry_in + shared_in : 2'h0);
                    sh = (x[15] & y[15]) | (x[15] & z[15]) | (y[15] & z[15]);
                    eq = t[15:0];
                    chk("shared_out", shared_out, sh);
                    chk("carry_out", carry_out, t[17:16] - sh);
                end
                3: eq = {eq[14:0], reg_chain_in};
                default: begin
                    // chain lives in modules 4 to 7 only; the free half adds its own pairs with no carry
                    s = {1'b0, x[15:8]} + y[15:8] + ((k == 5) ? carry_in : 1'b0);
                    for (j = 0; j < 8; j += 2)
                        eq[j +: 2] = x[j +: 2] + y[j +: 2];
                    eq[15:8] = s[7:0];
                    chk("carry_out", carry_out, s[8]);
                end
            endcase
        end
        @(negedge clk);
        chk("reg_q", reg_q, eq);
        clear_sel = $urandom;
        {clear_a, preset} = 2'h3;
        #1 chk("reg_q", reg_q, clear_sel);
        @(negedge clk);
        {global_clear_low, clear_a} = 2'h0;
        #1 chk("reg_q", reg_q, 16'h0000);
        @(negedge clk);
        global_clear_low = 1;
        #1 chk("reg_q", reg_q, 16'hffff);
        @(negedge clk);
        {preset, clear_b} = 2'h1;
        eq = ~clear_sel;
        #1 chk("reg_q", reg_q, eq);
        @(negedge clk);
        clear_b = 0;
        final_report;
    end
endmodule // logic_cluster_bench
